// ---- bsw_regs.svh ----
/*
  Constants of the boot shadow and watchdog block: register offsets, bit
  positions, reset values, memory map bounds and watchdog timing.
  Assumes it is included by bare name from the package and the design modules.
*/
// Overview of operation
// - boot mode is entered only by power-on or watchdog reset; software only leaves it
// - shadow clear: boot ROM at 0000h and 8000h, RAM read/write in data space
// - shadow set: ROM only at 8000h, RAM is code from 0000h, no writes
// - writing zero never clears shadow; only power-up or watchdog reset do
// - four reserved shadow register bits read zero, writes ignored
// - code-size field is hardwired 10b meaning 16K, untouched by reset
// - code-type bit is hardwired one, meaning RAM code space
// - device reset clears shadow bit and USB connect bit
// - first fetch after reset is at 0000h in boot ROM; RAM in data space
// - boot code reads EEPROM signature, copies firmware via data space or USB
// - firmware sets shadow first, then sets connect to start enumeration
// - watchdog counts 1 ms ticks, resets the core unless serviced in 128 ms
// - the tick comes from start-of-frame pulses, counting only while connected
// - writing one to service bit restarts counter; zero ignored; reads zero
// - watchdog disabled only when the six disable bits hold 101010b
// - disable bits reset to 00000 with the low bit one: watchdog enabled
// - reset-cause flag: zero after power-up, one after time-out, write one clears
// - F800h to FFFFh is the buffer and I/O area, top 128 are registers
// - register area: buffer manager EDB-0 only, DMA data regs and EDB-0 only
// - setup packet barred to DMA; endpoint-0 and data buffers open to all
`ifndef BSW_REGS_SVH
`define BSW_REGS_SVH

// ==========================================================================
// register offsets
`define BSW_ROM_SHADOW_CONFIG_OFS   16'hFF90
`define BSW_WATCHDOG_CTRL_OFS       16'hFF93
`define BSW_USB_CONTROL_OFS         16'hFFFC

// ==========================================================================
// field positions
`define BSW_SHADOW_BIT      0
`define BSW_SERVICE_BIT     0
`define BSW_DIS_UPPER_LSB   1
`define BSW_DIS_UPPER_MSB   5
`define BSW_CAUSE_BIT       6
`define BSW_DIS_LOW_BIT     7
`define BSW_CONNECT_BIT     7

// ==========================================================================
// fixed and reset values
`define BSW_CODE_TYPE_RAM   1'h1
`define BSW_CODE_SIZE_16K   2'h2
`define BSW_RSVD_ZERO       4'h0
`define BSW_DIS_UPPER_RST   5'h00
`define BSW_DIS_LOW_RST     1'h1
`define BSW_DIS_UPPER_KEY   5'h15
`define BSW_DIS_LOW_KEY     1'h0

// ==========================================================================
// memory map bounds
`define BSW_ROM_LO          16'h0000
`define BSW_ROM_HI          16'h27FF
`define BSW_ROM_ALT_LO      16'h8000
`define BSW_ROM_ALT_HI      16'hA7FF
`define BSW_RAM_LO          16'h0000
`define BSW_RAM_HI          16'h3FFF
`define BSW_IO_LO           16'hF800
`define BSW_MMR_LO          16'hFF80
`define BSW_EDB0_HI         16'hFF83
`define BSW_EDB_LO          16'hFF08
`define BSW_EDB_HI          16'hFF7F
`define BSW_SETUP_LO        16'hFF00
`define BSW_SETUP_HI        16'hFF07
`define BSW_DMA_DATA_LO     16'hFFA0
`define BSW_DMA_DATA_HI     16'hFFA1

// ==========================================================================
// watchdog timing
`define BSW_TICK_MS         1
`define BSW_WDT_TIMEOUT_MS  128
`define BSW_WDT_TICKS       (`BSW_WDT_TIMEOUT_MS / `BSW_TICK_MS)

`endif

// ---- bsw_pkg.sv ----
/*
  Types and shared helpers of the boot shadow and watchdog block.
  Assumes bsw_regs.svh is on the include path.
*/
`include "bsw_regs.svh"

package bsw_pkg;

  // ========================================================================
  // types
  typedef logic [15:0] bsw_addr_t;
  typedef logic [7:0]  bsw_byte_t;
  typedef enum logic {BSW_REQ_UBM, BSW_REQ_DMA} bsw_req_e;
  typedef enum {BSW_BOOT, BSW_NORMAL} bsw_mode_e;

  // ========================================================================
  // inclusive address window test, used by the access-check and memory-map decoders
  function automatic logic bsw_in_range(input bsw_addr_t a, input bsw_addr_t lo, input bsw_addr_t hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage

// ---- bsw_watchdog.sv ----
/*
  Seven-bit watchdog counter advanced by a 1 ms tick.
  Assumes tick is a one-cycle pulse and clear outranks counting.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bsw_regs.svh"

module bsw_watchdog #(
  parameter int unsigned TICKS = `BSW_WDT_TICKS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // control
  input  wire logic       wdt_clear,
  input  wire logic       wdt_run,
  input  wire logic       tick,
  // status
  output logic            timeout,
  output logic [6:0]      count
);
  import bsw_pkg::*;

  localparam logic [6:0] LAST = 7'(TICKS - 1);

  logic [6:0] next_count;
  logic       next_timeout;

  // ==========================================================================
  // counting; a disabled watchdog freezes rather than restarts
  always_comb begin
    next_count   = count;
    next_timeout = 1'b0;
    if (wdt_clear) begin
      next_count = 7'h00;
    end else if (wdt_run && tick) begin
      if (count == LAST) begin
        next_count   = 7'h00;
        next_timeout = 1'b1;
      end else begin
        next_count = count + 7'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count   <= 7'h00;
      timeout <= 1'b0;
    end else begin
      count   <= next_count;
      timeout <= next_timeout;
    end
  end

endmodule
`default_nettype wire

// ---- bsw_access_check.sv ----
/*
  Access rights of a bus requester (buffer manager or DMA) to the buffer area.
  Assumes the requester flags descriptor updates itself; the core needs no check.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bsw_regs.svh"

module bsw_access_check #(
  parameter bsw_pkg::bsw_req_e REQ = bsw_pkg::BSW_REQ_UBM
) (
  // request
  input  wire bsw_pkg::bsw_addr_t addr,
  input  wire logic               edb_update,
  // verdict
  output logic                    grant
);
  import bsw_pkg::*;

  logic in_mmr;
  logic in_edb0;
  logic in_edb;
  logic in_setup;
  logic in_data;

  // ==========================================================================
  // region decode
  always_comb begin
    in_mmr   = addr >= `BSW_MMR_LO;
    in_edb0  = bsw_in_range(addr, `BSW_MMR_LO, `BSW_EDB0_HI);
    in_edb   = bsw_in_range(addr, `BSW_EDB_LO, `BSW_EDB_HI);
    in_setup = bsw_in_range(addr, `BSW_SETUP_LO, `BSW_SETUP_HI);
    in_data  = bsw_in_range(addr, `BSW_IO_LO, 16'(`BSW_SETUP_LO - 16'h0001));
    grant    = 1'b0;
    if (in_mmr) begin
      grant = in_edb0 || (REQ == BSW_REQ_DMA && bsw_in_range(addr, `BSW_DMA_DATA_LO, `BSW_DMA_DATA_HI));
    end else if (in_edb) begin
      grant = edb_update;
    end else if (in_setup) begin
      grant = (REQ == BSW_REQ_UBM);
    end else if (in_data) begin
      grant = 1'b1;
    end
  end

endmodule
`default_nettype wire

// ---- bsw_top.sv ----
/*
  Boot shadow and watchdog block: memory map switching between boot and
  normal mode, the shadow configuration, watchdog and USB connect registers,
  the watchdog itself and access rights of buffer manager and DMA.
  Assumes a byte-wide data-space bus from the core with one-cycle read and
  write strobes, a one-cycle start-of-frame pulse, and sys_rst as power-on.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bsw_regs.svh"

module bsw_top #(
  parameter int unsigned WDT_TICKS = `BSW_WDT_TICKS
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // core data-space bus
  input  wire bsw_pkg::bsw_addr_t xaddr,
  input  wire logic               xwr,
  input  wire logic               xrd,
  input  wire bsw_pkg::bsw_byte_t xwdata,
  output bsw_pkg::bsw_byte_t      xrdata,
  output logic                    xreg_hit,
  // core code fetch
  input  wire bsw_pkg::bsw_addr_t code_addr,
  output logic                    code_rom_sel,
  output logic                    code_ram_sel,
  output logic [13:0]             rom_addr,
  output logic [13:0]             code_ram_addr,
  // data-space routing
  output logic                    xram_sel,
  output logic                    xram_we,
  output logic                    io_sel,
  // usb side
  input  wire logic               sof_pulse,
  output logic                    usb_connect_bit,
  // buffer manager and dma requests
  input  wire bsw_pkg::bsw_addr_t ubm_addr,
  input  wire logic               ubm_edb_update,
  output logic                    ubm_grant,
  input  wire bsw_pkg::bsw_addr_t dma_addr,
  input  wire logic               dma_edb_update,
  output logic                    dma_grant,
  // core reset request and state
  output logic                    mcu_rst,
  output logic                    shadow_switch_bit,
  output logic [6:0]              wdt_count
);
  import bsw_pkg::*;

  // ==========================================================================
  // state
  bsw_mode_e mode;
  bsw_mode_e next_mode;
  logic      connect;
  logic      next_connect;
  logic [4:0] watchdog_disable_upper;
  logic [4:0] next_dis_upper;
  logic      watchdog_disable_low;
  logic      next_dis_low;
  logic      reset_cause_flag;
  logic      next_cause;
  bsw_byte_t next_rdata;
  logic      next_mcu_rst;

  logic      timeout;
  logic      wr_shadow;
  logic      wr_wdog;
  logic      wr_usb;
  logic      service;
  logic      wdt_run;
  logic      wdt_clear;
  bsw_byte_t shadow_view;
  bsw_byte_t wdog_view;
  bsw_byte_t usb_view;

  // ==========================================================================
  // register decode
  always_comb begin
    wr_shadow = xwr && (xaddr == `BSW_ROM_SHADOW_CONFIG_OFS);
    wr_wdog   = xwr && (xaddr == `BSW_WATCHDOG_CTRL_OFS);
    wr_usb    = xwr && (xaddr == `BSW_USB_CONTROL_OFS);
    xreg_hit  = (xaddr == `BSW_ROM_SHADOW_CONFIG_OFS) || (xaddr == `BSW_WATCHDOG_CTRL_OFS)
                || (xaddr == `BSW_USB_CONTROL_OFS);
    service   = wr_wdog && xwdata[`BSW_SERVICE_BIT];
  end

  // ==========================================================================
  // read views; hardwired fields never pass through a flop, so reset leaves them
  always_comb begin
    shadow_switch_bit = (mode == BSW_NORMAL);
    shadow_view = {`BSW_CODE_TYPE_RAM, `BSW_CODE_SIZE_16K, `BSW_RSVD_ZERO,
                   shadow_switch_bit};
    wdog_view   = {watchdog_disable_low, reset_cause_flag, watchdog_disable_upper,
                   1'b0};                                            // service bit reads zero
    usb_view    = {connect, 7'h00};
    usb_connect_bit = connect;
  end

  // ==========================================================================
  // watchdog enable and tick; no frames means no tick, so a disconnected
  // device never times out
  always_comb begin
    wdt_run   = !((watchdog_disable_upper == `BSW_DIS_UPPER_KEY)
                  && (watchdog_disable_low == `BSW_DIS_LOW_KEY));
    wdt_clear = service || mcu_rst;
  end

  bsw_watchdog #(
    .TICKS     (WDT_TICKS)
  ) u_watchdog (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .wdt_clear (wdt_clear),
    .wdt_run   (wdt_run),
    .tick      (sof_pulse && connect),
    .timeout   (timeout),
    .count     (wdt_count)
  );

  // ==========================================================================
  // next register values; a watchdog reset acts like power-on except for
  // the cause flag, which it sets
  always_comb begin
    next_mode      = mode;
    next_connect   = connect;
    next_dis_upper = watchdog_disable_upper;
    next_dis_low   = watchdog_disable_low;
    next_cause     = reset_cause_flag;
    next_rdata     = xrdata;
    next_mcu_rst   = timeout;
    if (mcu_rst) begin
      next_mode      = BSW_BOOT;
      next_connect   = 1'b0;
      next_dis_upper = `BSW_DIS_UPPER_RST;
      next_dis_low   = `BSW_DIS_LOW_RST;
      next_cause     = 1'b1;
    end else begin
      // only a one can move the mode, and only forward
      if (wr_shadow && xwdata[`BSW_SHADOW_BIT]) begin
        next_mode = BSW_NORMAL;
      end
      if (wr_usb) begin
        next_connect = xwdata[`BSW_CONNECT_BIT];
      end
      if (wr_wdog) begin
        next_dis_upper = xwdata[`BSW_DIS_UPPER_MSB:`BSW_DIS_UPPER_LSB];
        next_dis_low   = xwdata[`BSW_DIS_LOW_BIT];
        if (xwdata[`BSW_CAUSE_BIT]) begin
          next_cause = 1'b0;
        end
      end
      // a time-out in the clearing cycle still leaves the flag set
      if (timeout) begin
        next_cause = 1'b1;
      end
    end
    if (xrd) begin
      case (xaddr)
        `BSW_ROM_SHADOW_CONFIG_OFS: next_rdata = shadow_view;
        `BSW_WATCHDOG_CTRL_OFS:     next_rdata = wdog_view;
        `BSW_USB_CONTROL_OFS:       next_rdata = usb_view;
        default:                    next_rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // register bank; power-on clears the cause flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode                   <= BSW_BOOT;
      connect                <= 1'b0;
      watchdog_disable_upper <= `BSW_DIS_UPPER_RST;
      watchdog_disable_low   <= `BSW_DIS_LOW_RST;
      reset_cause_flag       <= 1'b0;
      xrdata                 <= 8'h00;
      mcu_rst                <= 1'b0;
    end else begin
      mode                   <= next_mode;
      connect                <= next_connect;
      watchdog_disable_upper <= next_dis_upper;
      watchdog_disable_low   <= next_dis_low;
      reset_cause_flag       <= next_cause;
      xrdata                 <= next_rdata;
      mcu_rst                <= next_mcu_rst;
    end
  end

  // ==========================================================================
  // code-space map; boot mode serves 0000h from ROM so the first fetch
  // after any reset lands in the loader
  always_comb begin
    code_rom_sel  = 1'b0;
    code_ram_sel  = 1'b0;
    rom_addr      = 14'h0000;
    code_ram_addr = 14'h0000;
    if (bsw_in_range(code_addr, `BSW_ROM_ALT_LO, `BSW_ROM_ALT_HI)) begin
      code_rom_sel = 1'b1;
      rom_addr     = 14'(code_addr - `BSW_ROM_ALT_LO);
    end else if (mode == BSW_BOOT) begin
      if (bsw_in_range(code_addr, `BSW_ROM_LO, `BSW_ROM_HI)) begin
        code_rom_sel = 1'b1;
        rom_addr     = code_addr[13:0];
      end
    end else begin
      if (bsw_in_range(code_addr, `BSW_RAM_LO, `BSW_RAM_HI)) begin
        code_ram_sel  = 1'b1;
        code_ram_addr = code_addr[13:0];
      end
    end
  end

  // ==========================================================================
  // data-space map; in normal mode the RAM leaves data space, so no store
  // from the core can reach code
  always_comb begin
    xram_sel = (mode == BSW_BOOT) && bsw_in_range(xaddr, `BSW_RAM_LO, `BSW_RAM_HI);
    xram_we  = xram_sel && xwr;
    io_sel   = (xaddr >= `BSW_IO_LO) && !xreg_hit;
  end

  // ==========================================================================
  // access rights of the two other masters; the core is never checked
  bsw_access_check #(
    .REQ        (BSW_REQ_UBM)
  ) u_ubm_check (
    .addr       (ubm_addr),
    .edb_update (ubm_edb_update),
    .grant      (ubm_grant)
  );

  bsw_access_check #(
    .REQ        (BSW_REQ_DMA)
  ) u_dma_check (
    .addr       (dma_addr),
    .edb_update (dma_edb_update),
    .grant      (dma_grant)
  );

endmodule
`default_nettype wire

// ---- bsw_monitor.sv ----
/*
  Checker for the boot shadow and watchdog top ports.
  Assumes a bind from the testbench that hands on WDT_TICKS.
*/
`timescale 1ns/1ns
`default_nettype none
module bsw_monitor #(
  parameter int unsigned WDT_TICKS = 128
) (
  // clock and reset
  input wire logic               clk,
  input wire logic               sys_rst,
  // core bus
  input wire bsw_pkg::bsw_addr_t xaddr,
  input wire logic               xwr,
  input wire logic               xrd,
  input wire bsw_pkg::bsw_byte_t xwdata,
  input wire bsw_pkg::bsw_byte_t xrdata,
  // code and data map
  input wire bsw_pkg::bsw_addr_t code_addr,
  input wire logic               code_rom_sel,
  input wire logic               code_ram_sel,
  input wire logic [13:0]        rom_addr,
  input wire logic               xram_we,
  // watchdog, usb and grants
  input wire logic               sof_pulse,
  input wire logic               usb_connect_bit,
  input wire bsw_pkg::bsw_addr_t dma_addr,
  input wire logic               dma_grant,
  input wire logic               mcu_rst,
  input wire logic               shadow_switch_bit,
  input wire logic [6:0]         wdt_count
);
  import bsw_pkg::*;
  // ==========================================================
  // assertions, all in the one clock domain
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  shadow_hold_a: assert property (shadow_switch_bit && !mcu_rst |=> shadow_switch_bit)
    else $error("shadow bit dropped");
  shadow_set_a: assert property (xwr && xaddr == 16'hFF90 && xwdata[0] && !mcu_rst |=> shadow_switch_bit)
    else $error("shadow bit not set");
  boot_map_a: assert property (!shadow_switch_bit && code_addr <= 16'h27FF
    |-> code_rom_sel && !code_ram_sel && rom_addr == code_addr[13:0]) else $error("boot map wrong");
  normal_map_a: assert property (shadow_switch_bit && code_addr <= 16'h3FFF |-> code_ram_sel && !code_rom_sel)
    else $error("normal map wrong");
  ram_write_a: assert property (xwr && xaddr <= 16'h3FFF |-> xram_we == !shadow_switch_bit)
    else $error("ram write gate wrong");
  rst_clear_a: assert property (disable iff (1'b0) sys_rst |=> !shadow_switch_bit && !usb_connect_bit)
    else $error("reset left state");
  wdt_reset_a: assert property (mcu_rst |=> !mcu_rst && !shadow_switch_bit && !usb_connect_bit && wdt_count == 7'h00)
    else $error("watchdog reset incomplete");
  idle_hold_a: assert property (!(sof_pulse && usb_connect_bit) && !xwr && !mcu_rst |=> $stable(wdt_count))
    else $error("count moved without tick");
  service_clr_a: assert property (xwr && xaddr == 16'hFF93 && xwdata[0] |=> wdt_count == 7'h00)
    else $error("service did not clear");
  shadow_read_a: assert property (xrd && xaddr == 16'hFF90 |=> xrdata[7:1] == 7'h60)
    else $error("fixed bits wrong");
  wdt_cause_a: assert property (mcu_rst |-> $past(sof_pulse, 2) && $past(usb_connect_bit, 2))
    else $error("core reset without tick");
  dma_setup_a: assert property (dma_addr >= 16'hFF00 && dma_addr <= 16'hFF07 |-> !dma_grant)
    else $error("dma reached setup area");
  count_span_a: assert property (wdt_count < WDT_TICKS)
    else $error("count out of span");
  cover property (!shadow_switch_bit ##1 shadow_switch_bit);
  cover property (mcu_rst);
  cover property (dma_grant && dma_addr >= 16'hFF80);
endmodule
`default_nettype wire

// ---- bsw_core_model.sv ----
/*
  Behavioural core driving the block's data-space bus.
  Assumes the tb calls its tasks; one strobe per request, edge aligned.
*/
`timescale 1ns/1ns
`default_nettype none
module bsw_core_model (
  // clock
  input  wire logic               clk,
  // data-space bus
  output bsw_pkg::bsw_addr_t      xaddr,
  output logic                    xwr,
  output logic                    xrd,
  output bsw_pkg::bsw_byte_t      xwdata,
  input  wire bsw_pkg::bsw_byte_t xrdata
);
  import bsw_pkg::*;
  // idle bus at time zero
  initial begin
    xaddr = 16'h0000;
    xwdata = 8'h00;
    xwr = 1'b0;
    xrd = 1'b0;
  end
  // released lines turn over so stale values never look valid
  task automatic wr(input bsw_addr_t a, input bsw_byte_t d);
    @(posedge clk);
    xaddr <= a;
    xwdata <= d;
    xwr <= 1'b1;
    @(posedge clk);
    xwr <= 1'b0;
    xaddr <= ~a;
    xwdata <= ~d;
    #1;
  endtask
  // data is registered, so it is taken just after the strobe edge
  task automatic rd(input bsw_addr_t a, output bsw_byte_t d);
    @(posedge clk);
    xaddr <= a;
    xrd <= 1'b1;
    @(posedge clk);
    xrd <= 1'b0;
    xaddr <= ~a;
    #1;
    d = xrdata;
  endtask
  // firmware in place: leave boot mode before joining the bus
  task automatic go_normal();
    wr(16'hFF90, 8'h01);
    wr(16'hFFFC, 8'h80);
  endtask
  // keep disable bits at enabled value while servicing
  task automatic service();
    wr(16'hFF93, 8'h81);
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
/*
  Self-checking bench of the boot shadow and watchdog block.
  Assumes bsw_core_model drives the bus; watchdog span shortened to 4.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import bsw_pkg::*;
  localparam int unsigned WDT_TICKS = 4;
  logic clk, sys_rst, sof_pulse, ubm_edb_update, dma_edb_update, xwr, xrd;
  logic xreg_hit, code_rom_sel, code_ram_sel, xram_sel, xram_we, io_sel;
  logic usb_connect_bit, ubm_grant, dma_grant, mcu_rst, shadow_switch_bit;
  bsw_addr_t code_addr, ubm_addr, dma_addr, xaddr;
  bsw_byte_t xwdata, xrdata, rdv;
  logic [13:0] rom_addr, code_ram_addr;
  logic [6:0] wdt_count;
  int n_errors = 0;
  int checks_done = 0;
  // address, edb update, buffer manager grant, dma grant
  localparam logic [18:0] ROWS [18] = '{
    {16'hF7FF,3'b000}, {16'hF800,3'b011}, {16'hFEEF,3'b011}, {16'hFEFF,3'b011},
    {16'hFF00,3'b010}, {16'hFF07,3'b010}, {16'hFF08,3'b000}, {16'hFF08,3'b111},
    {16'hFF7F,3'b111}, {16'hFF7F,3'b000}, {16'hFF80,3'b011}, {16'hFF83,3'b011},
    {16'hFF84,3'b000}, {16'hFF90,3'b000}, {16'hFFA0,3'b001}, {16'hFFA1,3'b001},
    {16'hFFA2,3'b000}, {16'hFFFF,3'b000}};
  bsw_top #(.WDT_TICKS(WDT_TICKS)) i_dut (.clk(clk), .sys_rst(sys_rst), .xaddr(xaddr), .xwr(xwr),
    .xrd(xrd), .xwdata(xwdata), .xrdata(xrdata), .xreg_hit(xreg_hit), .code_addr(code_addr),
    .code_rom_sel(code_rom_sel), .code_ram_sel(code_ram_sel), .rom_addr(rom_addr),
    .code_ram_addr(code_ram_addr), .xram_sel(xram_sel), .xram_we(xram_we), .io_sel(io_sel),
    .sof_pulse(sof_pulse), .usb_connect_bit(usb_connect_bit), .ubm_addr(ubm_addr),
    .ubm_edb_update(ubm_edb_update), .ubm_grant(ubm_grant), .dma_addr(dma_addr),
    .dma_edb_update(dma_edb_update), .dma_grant(dma_grant), .mcu_rst(mcu_rst),
    .shadow_switch_bit(shadow_switch_bit), .wdt_count(wdt_count));
  bsw_core_model m (.clk(clk), .xaddr(xaddr), .xwr(xwr), .xrd(xrd), .xwdata(xwdata), .xrdata(xrdata));
  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic rc(input bsw_addr_t a, input bsw_byte_t e);
    m.rd(a, rdv);
    chk(rdv, e, "read");
  endtask
  // n start-of-frame pulses, state settled on return
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      sof_pulse <= 1'b1;
      @(posedge clk);
      sof_pulse <= 1'b0;
    end
    #1;
  endtask
  task automatic cmap(input bsw_addr_t a, input logic rom, input logic ram);
    @(posedge clk);
    code_addr <= a;
    #1;
    chk(code_rom_sel, rom, "rom select");
    chk(code_ram_sel, ram, "ram select");
    if (rom) chk(rom_addr, a[13:0], "rom offset");
    if (ram) chk(code_ram_addr, a[13:0], "ram offset");
  endtask
  // data-space routing {ram sel, ram we, io sel, reg hit} seen while a write stands
  task automatic dmap(input bsw_addr_t a, input logic [3:0] e);
    fork
      m.wr(a, 8'h00);
      begin
        @(posedge clk);
        #1;
        chk({xram_sel, xram_we, io_sel, xreg_hit}, e, "data map");
      end
    join
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock and hang guard, the run needs well under 1000 cycles
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50000;
    n_errors++;
    $display("[ERR] %0t run hung", $time);
    results();
  end
  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    sof_pulse = 1'b0;
    code_addr = 16'h0000;
    ubm_addr = 16'h0000;
    dma_addr = 16'h0000;
    ubm_edb_update = 1'b0;
    dma_edb_update = 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rc(16'hFF90, 8'hC0);
    rc(16'hFF93, 8'h80);
    rc(16'hFFFC, 8'h00);
    rc(16'hFF91, 8'h00);
    $display("test reset values done");
    foreach (ROWS[i]) begin
      @(posedge clk);
      ubm_addr <= ROWS[i][18:3];
      dma_addr <= ROWS[i][18:3];
      ubm_edb_update <= ROWS[i][2];
      dma_edb_update <= ROWS[i][2];
      #1;
      chk(ubm_grant, ROWS[i][1], "ubm grant");
      chk(dma_grant, ROWS[i][0], "dma grant");
    end
    $display("test access table done");
    cmap(16'h0000, 1'b1, 1'b0);
    cmap(16'h27FF, 1'b1, 1'b0);
    cmap(16'h3FFF, 1'b0, 1'b0);
    cmap(16'hA7FF, 1'b1, 1'b0);
    dmap(16'h1000, 4'b1100);
    dmap(16'hF800, 4'b0010);
    dmap(16'hFFFC, 4'b0001);
    m.wr(16'hFF90, 8'hFE);
    rc(16'hFF90, 8'hC0);
    tick(2);
    chk(wdt_count, 7'h00, "idle count");
    m.go_normal();
    chk(shadow_switch_bit, 1'b1, "shadow");
    rc(16'hFF90, 8'hC1);
    m.wr(16'hFF90, 8'h00);
    chk(shadow_switch_bit, 1'b1, "shadow kept");
    cmap(16'h0000, 1'b0, 1'b1);
    cmap(16'h3FFF, 1'b0, 1'b1);
    cmap(16'hA7FF, 1'b1, 1'b0);
    dmap(16'h1000, 4'b0000);
    $display("test memory map done");
    tick(3);
    chk(wdt_count, 7'h03, "count");
    m.wr(16'hFF93, 8'h80);
    chk(wdt_count, 7'h03, "zero service");
    m.service();
    chk(wdt_count, 7'h00, "service");
    rc(16'hFF93, 8'h80);
    m.wr(16'hFF93, 8'h2A);
    tick(2);
    chk(wdt_count, 7'h00, "disabled");
    m.wr(16'hFF93, 8'hAA);
    tick(1);
    chk(wdt_count, 7'h01, "near pattern runs");
    $display("test service and disable done");
    m.service();
    tick(4);
    chk(mcu_rst, 1'b0, "early core reset");
    @(posedge clk);
    #1;
    chk(mcu_rst, 1'b1, "core reset");
    @(posedge clk);
    #1;
    chk(shadow_switch_bit, 1'b0, "shadow after timeout");
    chk(usb_connect_bit, 1'b0, "connect after timeout");
    rc(16'hFF93, 8'hC0);
    m.wr(16'hFF93, 8'h80);
    rc(16'hFF93, 8'hC0);
    m.wr(16'hFF93, 8'hC1);
    rc(16'hFF93, 8'h80);
    $display("test timeout done");
    m.go_normal();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(shadow_switch_bit, 1'b0, "shadow after reset");
    chk(usb_connect_bit, 1'b0, "connect after reset");
    rc(16'hFF93, 8'h80);
    rc(16'hFF90, 8'hC0);
    $display("test second reset done");
    results();
  end
endmodule
bind bsw_top bsw_monitor #(.WDT_TICKS(WDT_TICKS)) i_mon (.clk(clk), .sys_rst(sys_rst), .xaddr(xaddr),
  .xwr(xwr), .xrd(xrd), .xwdata(xwdata), .xrdata(xrdata), .code_addr(code_addr),
  .code_rom_sel(code_rom_sel), .code_ram_sel(code_ram_sel), .rom_addr(rom_addr), .xram_we(xram_we),
  .sof_pulse(sof_pulse), .usb_connect_bit(usb_connect_bit), .dma_addr(dma_addr), .dma_grant(dma_grant),
  .mcu_rst(mcu_rst), .shadow_switch_bit(shadow_switch_bit), .wdt_count(wdt_count));
`default_nettype wire
